// >>> core/otc_cfg.svh
// Constants for the one-time-programmable trim control block.
`ifndef OTC_CFG_SVH
`define OTC_CFG_SVH
`define OTC_ADDR            6'h3E
`define OTC_PFX_WR          2'h0
`define OTC_PFX_RD          2'h1
`define OTC_OP_NONE         3'h0
`define OTC_OP_STD_READ     3'h1
`define OTC_OP_MARGIN       3'h2
`define OTC_OP_BLANK        3'h3
`define OTC_OP_BURN         3'h4
`define OTC_OP_END_TRIM     3'h7
`define OTC_OP_HI           23
`define OTC_OP_LO           21
`define OTC_DATA_HI         20
`define OTC_DATA_LO         13
`define OTC_FLAG_POS        12
`define OTC_RESET_TRIM      8'h01
`define OTC_CLK_MHZ         25
`define OTC_BURN_BASE_NS    2850
`define OTC_BURN_BIT_US     401
`define OTC_EOT_BURN_US     404
`define OTC_BURN_BASE_CYC   ((`OTC_BURN_BASE_NS * `OTC_CLK_MHZ + 999) / 1000)
`define OTC_BURN_BIT_CYC    (`OTC_BURN_BIT_US * `OTC_CLK_MHZ)
`define OTC_EOT_BURN_CYC    (`OTC_EOT_BURN_US * `OTC_CLK_MHZ)
`endif

// >>> core/otc_pkg.sv
// Types for the one-time-programmable trim control block.
package otc_pkg;
  typedef enum logic [1:0] {
    OTC_IDLE = 2'b00,
    OTC_BURN = 2'b01,
    OTC_READ = 2'b10
  } otc_state_t;

  typedef struct packed {
    logic [1:0] current_range;
    logic [1:0] peak_code;
    logic [1:0] offtime_code;
    logic [1:0] spare;
  } otc_trim_word_t;

  typedef struct packed {
    logic [7:0] cells;
    logic       finished;
  } otc_fuse_t;
endpackage

// >>> core/otc_trim_ctrl.sv
// Trim register, frame decode and antifuse sequencing over a serial port.
//
// How it works
// - Every 24-bit frame has an odd parity bit at bit 0.
// - Register write accepted only with opcode 100 and finished flag clear.
// - Opcode bits 23-21: 011 blank check, 010 margin, 001 standard read.
// - Opcode 100 burns the data bits selected in that frame.
// - Opcode 111 burns the end-of-trim fuse, marking trimming finished.
// - A read gives 0 for unwritten cells and 1 for written cells.
// - Blank check loads eight results into register bits 20 to 13.
// - Word burn lasts 2.85 us plus 401 us per selected bit.
// - End-of-trim burn lasts about 404 us.
// - Opcode 010 compares fuses against a lower resistance threshold.
// - Peak code maps 00,01,10,11 to 100000,000000,110001,111111.
`timescale 1ns/1ps
`include "otc_cfg.svh"
module otc_trim_ctrl (
  // Clock, enable and reset.
  input  wire logic                 mclk,
  input  wire logic                 clk_en,
  input  wire logic                 rst,
  // Serial port pins.
  input  wire logic                 spi_csn_n,
  input  wire logic                 spi_sck,
  input  wire logic                 spi_sdi,
  output logic                      spi_sdo,
  output logic                      spi_sdo_oe,
  // Antifuse array: cell levels as compared at each threshold.
  input  wire otc_pkg::otc_fuse_t   fuse_std,
  input  wire otc_pkg::otc_fuse_t   fuse_hi,
  input  wire otc_pkg::otc_fuse_t   fuse_lo,
  output otc_pkg::otc_fuse_t        burn_sel,
  output logic                      burn_active,
  // Trimmed defaults toward the buck logic.
  output otc_pkg::otc_trim_word_t   trim_defaults,
  output logic [5:0]                peak_setting_init,
  output logic                      trim_finished_flag
);
  import otc_pkg::*;

  localparam logic [19:0] BASE_CYC = 20'(`OTC_BURN_BASE_CYC);
  localparam logic [19:0] BIT_CYC  = 20'(`OTC_BURN_BIT_CYC);
  localparam logic [19:0] EOT_CYC  = 20'(`OTC_EOT_BURN_CYC);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] csn_s, sck_s, sdi_s;
  logic       sck_d;
  always_ff @(posedge mclk) begin
    if (rst) begin
      csn_s <= 2'b11;
      sck_s <= 2'b00;
      sdi_s <= 2'b00;
      sck_d <= 1'b0;
    end else if (clk_en) begin
      csn_s <= {csn_s[0], spi_csn_n};
      sck_s <= {sck_s[0], spi_sck};
      sdi_s <= {sdi_s[0], spi_sdi};
      sck_d <= sck_s[1];
    end
  end
  wire sck_rise = sck_s[1] & ~sck_d;
  wire sck_fall = ~sck_s[1] & sck_d;
  wire sel      = ~csn_s[1];

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  logic [23:0] rx_reg, tx_reg;
  logic [4:0]  cnt_reg;
  logic        sel_d;
  wire         frame_end = sel_d & ~sel & (cnt_reg == 5'd24);
  wire         par_ok    = ^rx_reg;
  wire         is_wr     = rx_reg[23:22] == `OTC_PFX_WR;
  wire         addr_ok   = rx_reg[21:16] == `OTC_ADDR;
  wire         frame_ok  = frame_end & par_ok & addr_ok;
  wire [2:0]   wr_op     = rx_reg[15:13];
  wire [7:0]   wr_data   = rx_reg[12:5];

  // State and register declarations.
  otc_state_t  state_reg;
  logic [7:0]  ct_data_reg;
  logic [2:0]  ct_op_reg;
  logic [19:0] tmr_reg;
  logic        burn_eot_reg;
  logic [7:0]  burn_word_reg;

  // Odd parity on an outgoing frame body.
  function automatic logic [23:0] otc_frame(input logic [22:0] body);
    otc_frame = {body, ~^body};
  endfunction

  wire [23:0] read_frame = otc_frame({ct_op_reg, ct_data_reg,
                                      trim_finished_flag, 11'h000});

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_reg  <= 24'h00_0000;
      tx_reg  <= 24'h00_0000;
      cnt_reg <= 5'd0;
      sel_d   <= 1'b0;
      spi_sdo <= 1'b0;
    end else if (clk_en) begin
      sel_d <= sel;
      if (sel & ~sel_d) begin
        cnt_reg <= 5'd0;
        tx_reg  <= read_frame;
        spi_sdo <= read_frame[23];
      end else if (sel & sck_rise & (cnt_reg != 5'd24)) begin
        rx_reg  <= {rx_reg[22:0], sdi_s[1]};
        cnt_reg <= cnt_reg + 5'd1;
      end else if (sel & sck_fall) begin
        tx_reg  <= {tx_reg[22:0], 1'b0};
        spi_sdo <= tx_reg[22];
      end
    end
  end
  assign spi_sdo_oe = sel;

  // ----------------------------------------------------------------
  // Opcode execution and burn timing
  // ----------------------------------------------------------------
  // A write frame body is prefix, address, opcode, then data bits.
  wire wr_frame  = frame_ok & is_wr & (state_reg == OTC_IDLE);
  wire burn_go   = wr_frame & (wr_op == `OTC_OP_BURN)
                   & ~trim_finished_flag;
  wire eot_go    = wr_frame & (wr_op == `OTC_OP_END_TRIM)
                   & ~trim_finished_flag;
  wire read_go   = wr_frame & ((wr_op == `OTC_OP_BLANK)
                   | (wr_op == `OTC_OP_MARGIN)
                   | (wr_op == `OTC_OP_STD_READ));

  logic [3:0] nbits;
  always_comb begin
    nbits = 4'd0;
    for (int i = 0; i < 8; i++) nbits = nbits + {3'd0, wr_data[i]};
  end
  wire [19:0] burn_cyc = 20'(BASE_CYC + BIT_CYC * nbits);

  // Pick the compare threshold for the read opcode.
  wire [7:0] read_sel = (ct_op_reg == `OTC_OP_BLANK)  ? fuse_hi.cells :
                        (ct_op_reg == `OTC_OP_MARGIN) ? fuse_lo.cells :
                        fuse_std.cells;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg     <= OTC_IDLE;
      ct_data_reg   <= 8'h00;
      ct_op_reg     <= `OTC_OP_NONE;
      tmr_reg       <= 20'd0;
      burn_eot_reg  <= 1'b0;
      burn_word_reg <= 8'h00;
    end else if (clk_en) begin
      unique case (state_reg)
        OTC_IDLE: begin
          if (burn_go) begin
            ct_op_reg     <= wr_op;
            ct_data_reg   <= wr_data;
            burn_word_reg <= wr_data;
            burn_eot_reg  <= 1'b0;
            tmr_reg       <= burn_cyc;
            state_reg     <= OTC_BURN;
          end else if (eot_go) begin
            ct_op_reg    <= wr_op;
            burn_eot_reg <= 1'b1;
            tmr_reg      <= EOT_CYC;
            state_reg    <= OTC_BURN;
          end else if (read_go) begin
            ct_op_reg <= wr_op;
            state_reg <= OTC_READ;
          end
        end
        OTC_BURN: begin
          if (tmr_reg <= 20'd1) state_reg <= OTC_IDLE;
          else tmr_reg <= tmr_reg - 20'd1;
        end
        OTC_READ: begin
          ct_data_reg <= read_sel;
          state_reg   <= OTC_IDLE;
        end
        default: state_reg <= OTC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs toward the array and the buck defaults
  // ----------------------------------------------------------------
  assign burn_active = state_reg == OTC_BURN;
  assign burn_sel.cells    = burn_active & ~burn_eot_reg ? burn_word_reg
                                                         : 8'h00;
  assign burn_sel.finished = burn_active & burn_eot_reg;

  // Trimmed defaults follow the standard-threshold fuse content.
  always_ff @(posedge mclk) begin
    if (rst) begin
      trim_defaults      <= otc_trim_word_t'(`OTC_RESET_TRIM);
      trim_finished_flag <= 1'b0;
    end else if (clk_en) begin
      trim_defaults      <= otc_trim_word_t'(fuse_std.cells);
      trim_finished_flag <= fuse_std.finished;
    end
  end

  always_comb begin
    unique case (trim_defaults.peak_code)
      2'b00: peak_setting_init = 6'h20;
      2'b01: peak_setting_init = 6'h00;
      2'b10: peak_setting_init = 6'h31;
      2'b11: peak_setting_init = 6'h3F;
    endcase
  end
endmodule // otc_trim_ctrl

// >>> verification/otc_trim_ctrl_props.sv
// Checker of the trim control block.
`timescale 1ns/1ps
module otc_trim_ctrl_props (
  // Clock and reset.
  input wire logic                   mclk,
  input wire logic                   rst,
  // Watched pins.
  input wire logic                   spi_csn_n,
  input wire otc_pkg::otc_fuse_t     fuse_std,
  input wire otc_pkg::otc_fuse_t     burn_sel,
  input wire logic                   burn_active,
  input wire otc_pkg::otc_trim_word_t trim_defaults,
  input wire logic [5:0]             peak_setting_init,
  input wire logic                   trim_finished_flag
);
  import otc_pkg::*;
  // ------
  // Burn length
  // ------
  // Holding the last selection lets the length check run after release.
  logic [16:0] len_reg;
  otc_fuse_t   sel_reg;
  always_ff @(posedge mclk) begin
    len_reg <= (rst || !burn_active) ? 17'h0_0000 : len_reg + 17'h0_0001;
    sel_reg <= burn_active ? burn_sel : sel_reg;
  end
  AST_WORD_LEN: assert property (@(posedge mclk) disable iff (rst)
    $fell(burn_active) && !sel_reg.finished |->
    len_reg == 17'h0_0048 + 17'h0_2729 * $countones(sel_reg.cells))
    else $error("word burn length wrong");
  AST_EOT_LEN: assert property (@(posedge mclk) disable iff (rst)
    $fell(burn_active) && sel_reg.finished |-> len_reg == 17'h0_2774)
    else $error("end burn length wrong");
  AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (rst)
    burn_active && $past(burn_active) |-> $stable(burn_sel))
    else $error("burn selection moved");
  AST_SEL_KIND: assert property (@(posedge mclk) disable iff (rst)
    burn_active |-> !(burn_sel.finished && burn_sel.cells != 8'h00))
    else $error("word and end fuse burned together");
  AST_LOCK: assert property (@(posedge mclk) disable iff (rst)
    trim_finished_flag |-> !$rose(burn_active))
    else $error("burn after trimming finished");
  AST_FLAG: assert property (@(posedge mclk) disable iff (rst)
    $rose(fuse_std.finished) |-> ##[1:3] trim_finished_flag)
    else $error("finished flag not reported");
  AST_AFTER_FRAME: assert property (@(posedge mclk) disable iff (rst)
    $rose(burn_active) |-> spi_csn_n && $past(spi_csn_n, 3))
    else $error("burn started inside a frame");
  AST_PEAK: assert property (@(posedge mclk) disable iff (rst)
    peak_setting_init == (trim_defaults.peak_code == 2'h0 ? 6'h20 :
    trim_defaults.peak_code == 2'h1 ? 6'h00 :
    trim_defaults.peak_code == 2'h2 ? 6'h31 : 6'h3F))
    else $error("peak setting decode wrong");
endmodule // otc_trim_ctrl_props
bind otc_trim_ctrl otc_trim_ctrl_props otc_trim_ctrl_props_i (.mclk, .rst,
  .spi_csn_n, .fuse_std, .burn_sel, .burn_active, .trim_defaults,
  .peak_setting_init, .trim_finished_flag);

// >>> verification/otc_spi_master.sv
// Test controller model driving whole frames on the serial pins.
`timescale 1ns/1ps
module otc_spi_master (
  // Clock.
  input  wire logic mclk,
  // Serial pins.
  output logic      spi_csn_n = 1'b1,
  output logic      spi_sck = 1'b0,
  output logic      spi_sdi = 1'b0,
  input  wire logic spi_sdo
);
  // ------
  // Frame transfer
  // ------
  // The serial clock stands still between frames; data in is inverted
  // after release so a stale level is never mistaken for a live bit.
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    @(negedge mclk);
    spi_csn_n = 1'b0;
    repeat (2) @(negedge mclk);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = tx[i];
      repeat (4) @(negedge mclk);
      spi_sck = 1'b1;
      rx[i] = spi_sdo;
      repeat (4) @(negedge mclk);
      spi_sck = 1'b0;
    end
    repeat (2) @(negedge mclk);
    spi_csn_n = 1'b1;
    spi_sdi = ~spi_sdi;
  endtask
endmodule // otc_spi_master

// >>> verification/otc_trim_ctrl_test.sv
// Self-checking bench for the trim control block.
`timescale 1ns/1ps
`include "otc_cfg.svh"
module otc_trim_ctrl_test;
  import otc_pkg::*;
  logic           mclk = 1'b0;
  logic           rst = 1'b1;
  logic           clk_en = 1'b1;
  logic           spi_csn_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe;
  logic           burn_active, trim_finished_flag;
  logic [5:0]     peak_setting_init;
  logic [23:0]    rx;
  otc_fuse_t      fuse_std = '0, fuse_hi = '0, fuse_lo = '0;
  otc_fuse_t      burn_sel, seen_sel;
  otc_trim_word_t trim_defaults;
  int             miscompares = 0, checks = 0, cycles = 0, len;
  otc_trim_ctrl otc_trim_ctrl_i (.mclk, .clk_en, .rst, .spi_csn_n, .spi_sck,
    .spi_sdi, .spi_sdo, .spi_sdo_oe, .fuse_std, .fuse_hi, .fuse_lo,
    .burn_sel, .burn_active, .trim_defaults, .peak_setting_init,
    .trim_finished_flag);
  otc_spi_master otc_spi_master_i (.mclk, .spi_csn_n, .spi_sck, .spi_sdi,
    .spi_sdo);
  // ------
  // Helpers
  // ------
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] frame(logic [1:0] p, logic [2:0] op,
                                        logic [7:0] d);
    frame[23:1] = {p, 6'h3E, op, d, 4'h0};
    frame[0] = ~^frame[23:1];
  endfunction
  task automatic burn(input logic [23:0] f);
    otc_spi_master_i.xfer(f, rx);
    len = 0;
    for (int i = 0; i < 40 && burn_active !== 1'b1; i++) @(negedge mclk);
    seen_sel = burn_sel;
    while (burn_active === 1'b1 && len < 20000) begin
      @(negedge mclk);
      len++;
    end
  endtask
  // Starts one read operation, then reads the register image back.
  task automatic rd_op(input logic [2:0] op, input logic [7:0] exp);
    otc_spi_master_i.xfer(frame(2'h0, op, 8'h00), rx);
    repeat (10) @(negedge mclk);
    otc_spi_master_i.xfer(frame(2'h1, 3'h0, 8'h00), rx);
    check(rx[20:13], exp);
    check(rx[23:21], op);
    check(^rx, 1'b1);
  endtask
  task automatic t_reads;
    check(trim_defaults, 32'h0000_0000);
    fuse_hi.cells = 8'h81;
    fuse_lo.cells = 8'h42;
    fuse_std.cells = 8'h9C;
    rd_op(`OTC_OP_BLANK, 8'h81);
    check(rx[18:15], 4'h0);
    rd_op(`OTC_OP_MARGIN, 8'h42);
    rd_op(`OTC_OP_STD_READ, 8'h9C);
    $display("reads done");
  endtask
  task automatic t_verify;
    fuse_lo.cells = 8'h10;
    rd_op(`OTC_OP_MARGIN, 8'h10);
    fuse_hi.cells = 8'h10;
    rd_op(`OTC_OP_BLANK, 8'h10);
    $display("verify done");
  endtask
  task automatic t_defaults;
    logic [5:0] peak [4] = '{6'h20, 6'h00, 6'h31, 6'h3F};
    for (int c = 0; c < 4; c++) begin
      fuse_std.cells = {2'h2, c[1:0], 4'h5};
      repeat (3) @(negedge mclk);
      check(trim_defaults, {2'h2, c[1:0], 4'h5});
      check(peak_setting_init, peak[c]);
    end
    clk_en = 1'b0;
    fuse_std.cells = 8'h00;
    repeat (3) @(negedge mclk);
    check(trim_defaults, 32'h0000_00B5);
    clk_en = 1'b1;
    repeat (3) @(negedge mclk);
    check(trim_defaults, 32'h0000_0000);
    $display("defaults done");
  endtask
  task automatic t_parity;
    otc_spi_master_i.xfer(frame(2'h0, `OTC_OP_BURN, 8'h01) ^ 24'h00_0001, rx);
    repeat (20) @(negedge mclk);
    check(burn_active, 1'b0);
    check(spi_sdo_oe, 1'b0);
    $display("parity done");
  endtask
  task automatic t_burn;
    for (int i = 0; i < 3; i++) begin
      burn(frame(2'h0, `OTC_OP_BURN, 8'h10));
      check(seen_sel, {8'h10, 1'b0});
      check(len, 32'h0000_2771);
    end
    $display("burn done");
  endtask
  task automatic t_end_trim;
    for (int i = 0; i < 3; i++) begin
      burn(frame(2'h0, `OTC_OP_END_TRIM, 8'h00));
      check(seen_sel, 32'h0000_0001);
      check(len, 32'h0000_2774);
    end
    fuse_std.finished = 1'b1;
    repeat (3) @(negedge mclk);
    check(trim_finished_flag, 1'b1);
    burn(frame(2'h0, `OTC_OP_BURN, 8'h01));
    check(len, 32'h0000_0000);
    $display("end trim done");
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    @(negedge mclk);
    check(trim_defaults, `OTC_RESET_TRIM);
    @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    t_reads();
    t_defaults();
    t_parity();
    t_burn();
    t_verify();
    t_end_trim();
    test_done();
  end
endmodule // otc_trim_ctrl_test
